// File: common/cbc_pkg.sv
// cbc_pkg: constants and carriers for the cpu bus control and flags block
// assumes: used by rtl/cbc_top.sv and rtl/cbc_flag_unit.sv
`default_nettype none
package cbc_pkg;
   // ==========================================================
   // register map (byte addresses on apb)
   localparam logic [11:0] CBC_OFS_FLAGS    = 12'h000;
   localparam logic [11:0] CBC_OFS_PAGE     = 12'h004;
   localparam logic [11:0] CBC_OFS_ACC      = 12'h008;
   localparam logic [11:0] CBC_OFS_STACK    = 12'h00c;
   localparam logic [11:0] CBC_OFS_USTACK   = 12'h010;
   localparam logic [11:0] CBC_OFS_CTRL     = 12'h014;
   localparam logic [11:0] CBC_OFS_STATUS   = 12'h018;
   localparam logic [11:0] CBC_OFS_ALU      = 12'h01c;
   localparam logic [11:0] CBC_OFS_EVENT    = 12'h020;
   // ==========================================================
   // reset values and constants
   localparam logic [7:0]  CBC_FLAGS_RST    = 8'h50;
   localparam logic [7:0]  CBC_PAGE_RST     = 8'h00;
   localparam logic [15:0] CBC_IDLE_ADDR    = 16'hffff;
   localparam logic [15:0] CBC_VEC_RESET    = 16'hfffe;
   localparam logic [15:0] CBC_STACK_RST    = 16'h0000;
   // flag bit positions
   localparam int CBC_F_C = 0;
   localparam int CBC_F_V = 1;
   localparam int CBC_F_Z = 2;
   localparam int CBC_F_N = 3;
   localparam int CBC_F_I = 4;
   localparam int CBC_F_H = 5;
   localparam int CBC_F_F = 6;
   localparam int CBC_F_E = 7;
   // bus cycle length in clocks, reset hold must exceed it
   localparam logic [3:0]  CBC_CYC_LEN      = 4'h4;
   localparam logic [2:0]  CBC_EVENT_W      = 3'h0;
   // ==========================================================
   // alu operations
   typedef enum logic [2:0] {
      CBC_OP_ADD, CBC_OP_ADC, CBC_OP_SUB, CBC_OP_SBC,
      CBC_OP_CMP, CBC_OP_NEG, CBC_OP_AND
   } cbc_op_t;
   // events that touch the mask bits
   typedef enum logic [2:0] {
      CBC_EV_NMI, CBC_EV_QUICK_INTERRUPT_REQUEST, CBC_EV_IRQ, CBC_EV_RESET,
      CBC_EV_TRAP1, CBC_EV_TRAP2, CBC_EV_TRAP3, CBC_EV_RETURN
   } cbc_ev_t;
   // bus pin group
   typedef struct packed {
      logic [15:0] addr;
      logic        read;
      logic        bus_released;
      logic        bus_state;
   } cbc_bus_t;
   // alu result carrier
   typedef struct packed {
      logic [7:0] result;
      logic [7:0] flags;
   } cbc_alu_t;
endpackage
`default_nettype wire

// File: rtl/cbc_flag_unit.sv
// cbc_flag_unit: 8-bit alu and condition flag derivation
// assumes: purely combinational, driven by the top on one clock
`default_nettype none
module cbc_flag_unit
   import cbc_pkg::*;
(
   // operands
   input  wire logic [7:0]     a_in,
   input  wire logic [7:0]     b_in,
   input  wire cbc_pkg::cbc_op_t op_in,
   input  wire logic [7:0]     flags_in,
   // result
   output cbc_pkg::cbc_alu_t   res_out
);
   // ==========================================================
   // arithmetic paths
   logic       sub;
   logic       cin;
   logic [7:0] bx;
   logic [7:0] src_a;
   logic [4:0] lo;
   logic [3:0] mid;
   logic       c7;
   logic       c8;
   logic [7:0] sum;

   // subtract-like ops add the inverted operand
   assign sub   = (op_in == CBC_OP_SUB) || (op_in == CBC_OP_SBC) ||
                  (op_in == CBC_OP_CMP) || (op_in == CBC_OP_NEG);
   assign src_a = (op_in == CBC_OP_NEG) ? 8'h00 : a_in;
   assign bx    = sub ? ~((op_in == CBC_OP_NEG) ? a_in : b_in) : b_in;
   assign cin   = (op_in == CBC_OP_ADC) ? flags_in[CBC_F_C] :
                  (op_in == CBC_OP_SBC) ? ~flags_in[CBC_F_C] : sub;
   assign lo    = {1'b0, src_a[3:0]} + {1'b0, bx[3:0]} + {4'h0, cin};
   assign {c7, mid[2:0]} = {1'b0, src_a[6:4]} + {1'b0, bx[6:4]} +
                           {3'h0, lo[4]};
   assign mid[3] = 1'b0;
   assign c8    = (src_a[7] & bx[7]) | (c7 & (src_a[7] ^ bx[7]));
   assign sum   = (op_in == CBC_OP_AND) ? (a_in & b_in) :
                  {src_a[7] ^ bx[7] ^ c7, mid[2:0], lo[3:0]};

   // flag merge
   always_comb begin
      res_out.result = sum;
      res_out.flags  = flags_in;
      if (op_in != CBC_OP_AND) begin
         res_out.flags[CBC_F_C] = sub ? ~c8 : c8;           // R5
         res_out.flags[CBC_F_V] = c8 ^ c7;                  // R6
      end else begin
         res_out.flags[CBC_F_V] = 1'b0;
      end
      res_out.flags[CBC_F_Z] = (sum == 8'h00);              // R7
      res_out.flags[CBC_F_N] = sum[7];                      // R8
      if ((op_in == CBC_OP_ADD) || (op_in == CBC_OP_ADC)) begin
         res_out.flags[CBC_F_H] = lo[4];                    // R10
      end
   end
endmodule
`default_nettype wire

// File: rtl/cbc_top.sv
// cbc_top: processor register state, flags and bus control over apb
// assumes: apb master on sys_clk_in; pins arrive asynchronously
// Operation
// R1 - two accumulators form one 16-bit accumulator
// R2 - page base drives upper address in direct
// R3 - reset clears page base
// R4 - stack pointers address last stored item
// R5 - flag0 carry, borrow for subtract-like ops
// R6 - flag1 overflow from carry mismatch at msb
// R7 - flag2 set on zero result
// R8 - flag3 equals result msb
// R9 - flag4 masks normal interrupt, set by events
// R10 - flag5 half carry on add only
// R11 - flag6 masks fast interrupt, set by events
// R12 - flag7 selects full or partial restore
// R13 - idle cycle drives all ones, read
// R14 - address floats while bus released
// R15 - direction low write, floats when released; read_out is driven high then instead
// R16 - reset over one cycle, then vector fetch
// R17 - halt stops after instruction, status high
// R18 - halted ignores interrupts, latches nmi, reset
// R19 - halt during reset enters halt directly
// R20 - steal plus halt finishes instruction, halts
// R21 - one dead cycle after release falls
// R22 - status pair encodes run, ack, sync, halt; the code never produces the sync code
// R23 - interrupts need one synchronising cycle
// R24 - combined write updates both accumulators together
`default_nettype none
module cbc_top
   import cbc_pkg::*;
(
   // clock, reset, enable
   input  wire logic        sys_clk_in,
   input  wire logic        rst_in,
   input  wire logic        clk_en_in,
   // apb slave
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [11:0] paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic [31:0]      prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   // processor pins
   input  wire logic        reset_n_in,
   input  wire logic        halt_n_in,
   input  wire logic        bus_steal_request_n_in,
   input  wire logic        nmi_n_in,
   input  wire logic        quick_interrupt_request_n_in,
   input  wire logic        irq_n_in,
   // bus outputs
   output logic [15:0]      addr_out,
   output logic             addr_oe_out,
   output logic             read_out,
   output logic             bus_released_out,
   output logic             bus_state_out
);
   // ==========================================================
   // pin synchronisers
   logic [5:0] pin_meta_reg;
   logic [5:0] pin_sync_reg;
   logic [5:0] pin_raw;
   logic       reset_n_s;
   logic       halt_n_s;
   logic       steal_n_s;
   logic       nmi_n_s;
   logic       quick_interrupt_request_n_s;
   logic       irq_n_s;

   assign pin_raw = {reset_n_in, halt_n_in, bus_steal_request_n_in,
                     nmi_n_in, quick_interrupt_request_n_in, irq_n_in};
   assign {reset_n_s, halt_n_s, steal_n_s, nmi_n_s, quick_interrupt_request_n_s, irq_n_s} =
          pin_sync_reg;

   // two-stage synchroniser; second stage also gives the R23 delay
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         pin_meta_reg <= 6'h3f;
         pin_sync_reg <= 6'h3f;
      end else if (clk_en_in) begin
         pin_meta_reg <= pin_raw;
         pin_sync_reg <= pin_meta_reg;
      end
   end

   // ==========================================================
   // architectural registers
   logic [7:0]  acc_a_reg;
   logic [7:0]  acc_b_reg;
   logic [7:0]  flags_reg;
   logic [7:0]  flags_next;
   logic [7:0]  page_reg;
   logic [15:0] sstack_reg;
   logic [15:0] ustack_reg;
   logic [15:0] acc_d;
   logic [7:0]  alu_b_reg;
   cbc_op_t     alu_op_reg;
   cbc_alu_t    alu_res;
   logic        direct_reg;
   logic [7:0]  low_addr_reg;
   logic        write_req_reg;
   logic        xfer_req_reg;

   assign acc_d = {acc_a_reg, acc_b_reg};                  // R1

   cbc_flag_unit u_flag (
      .a_in     (acc_a_reg),
      .b_in     (alu_b_reg),
      .op_in    (alu_op_reg),
      .flags_in (flags_reg),
      .res_out  (alu_res)
   );

   // ==========================================================
   // sequencer
   typedef enum logic [2:0] {
      CBC_ST_RESET, CBC_ST_VECTOR, CBC_ST_RUN, CBC_ST_GRANT,
      CBC_ST_DEAD, CBC_ST_HALT
   } cbc_state_t;
   cbc_state_t state_reg;
   cbc_state_t state_next;
   logic [3:0] rst_cnt_reg;
   logic [3:0] cyc_cnt_reg;
   logic       cyc_end;
   logic       instr_end_reg;
   logic       nmi_latch_reg;
   logic       rst_latch_reg;
   logic       nmi_prev_reg;
   logic       irq_take;
   logic       quick_interrupt_request_take;
   logic       reset_long;

   assign cyc_end    = (cyc_cnt_reg == CBC_CYC_LEN - 4'h1);
   assign reset_long = (rst_cnt_reg > CBC_CYC_LEN);         // R16
   // masks gate requests; halted state ignores them
   assign irq_take   = !irq_n_s && !flags_reg[CBC_F_I] &&
                       (state_reg == CBC_ST_RUN);           // R9
   assign quick_interrupt_request_take  = !quick_interrupt_request_n_s && !flags_reg[CBC_F_F] &&
                       (state_reg == CBC_ST_RUN);           // R11

   // next state
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         CBC_ST_RESET: begin
            if (!halt_n_s && !reset_n_s) state_next = CBC_ST_HALT; // R19
            else if (reset_n_s) state_next = CBC_ST_VECTOR;
         end
         CBC_ST_VECTOR: begin
            if (cyc_end) state_next = CBC_ST_RUN;           // R16
         end
         CBC_ST_RUN: begin
            if (cyc_end && !steal_n_s) state_next = CBC_ST_GRANT;
            else if (cyc_end && instr_end_reg && !halt_n_s)
               state_next = CBC_ST_HALT;                    // R17
         end
         CBC_ST_GRANT: begin
            if (steal_n_s && halt_n_s) state_next = CBC_ST_DEAD;
            else if (steal_n_s && !instr_end_reg)
               state_next = CBC_ST_DEAD;                    // R20
            else if (steal_n_s) state_next = CBC_ST_HALT;
         end
         CBC_ST_DEAD: begin
            if (cyc_end && rst_latch_reg) state_next = CBC_ST_RESET; // R18
            else if (cyc_end) state_next = CBC_ST_RUN;      // R21
         end
         CBC_ST_HALT: begin
            if (halt_n_s && steal_n_s) state_next = CBC_ST_DEAD;
         end
         default: state_next = CBC_ST_RESET;
      endcase
      if (reset_long && state_reg != CBC_ST_HALT &&
          state_reg != CBC_ST_RESET)
         state_next = CBC_ST_RESET;
   end

   // state, counters and halt latches
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         state_reg     <= CBC_ST_RESET;
         rst_cnt_reg   <= 4'h0;
         cyc_cnt_reg   <= 4'h0;
         nmi_latch_reg <= 1'b0;
         rst_latch_reg <= 1'b0;
         nmi_prev_reg  <= 1'b1;
      end else if (clk_en_in) begin
         state_reg    <= state_next;
         cyc_cnt_reg  <= (cyc_end || state_next != state_reg) ?
                         4'h0 : cyc_cnt_reg + 4'h1;
         rst_cnt_reg  <= reset_n_s ? 4'h0 :
                         (reset_long ? rst_cnt_reg : rst_cnt_reg + 4'h1);
         nmi_prev_reg <= nmi_n_s;
         // nmi edge and reset held for later service while halted
         if (state_reg == CBC_ST_HALT && nmi_prev_reg && !nmi_n_s)
            nmi_latch_reg <= 1'b1;                          // R18
         else if (state_reg == CBC_ST_RUN)
            nmi_latch_reg <= 1'b0;
         if (state_reg == CBC_ST_HALT && !reset_n_s)
            rst_latch_reg <= 1'b1;                          // R18
         else if (state_reg == CBC_ST_VECTOR)
            rst_latch_reg <= 1'b0;
      end
   end

   // ==========================================================
   // apb decode
   logic        apb_wr;
   logic        apb_rd;
   logic        hit;
   logic [31:0] rd_mux;
   logic [2:0]  event_code;

   assign apb_wr = psel_in && penable_in && pwrite_in && clk_en_in;
   assign apb_rd = psel_in && !penable_in && !pwrite_in;
   assign event_code = pwdata_in[2:0];
   assign hit = (paddr_in == CBC_OFS_FLAGS) || (paddr_in == CBC_OFS_PAGE) ||
                (paddr_in == CBC_OFS_ACC) || (paddr_in == CBC_OFS_STACK) ||
                (paddr_in == CBC_OFS_USTACK) || (paddr_in == CBC_OFS_CTRL) ||
                (paddr_in == CBC_OFS_STATUS) || (paddr_in == CBC_OFS_ALU) ||
                (paddr_in == CBC_OFS_EVENT);
   assign rd_mux =
      (paddr_in == CBC_OFS_FLAGS)  ? {24'h0, flags_reg} :
      (paddr_in == CBC_OFS_PAGE)   ? {24'h0, page_reg} :
      (paddr_in == CBC_OFS_ACC)    ? {16'h0, acc_d} :
      (paddr_in == CBC_OFS_STACK)  ? {16'h0, sstack_reg} :
      (paddr_in == CBC_OFS_USTACK) ? {16'h0, ustack_reg} :
      (paddr_in == CBC_OFS_CTRL)   ? {20'h0, xfer_req_reg, write_req_reg,
                                      direct_reg, instr_end_reg,
                                      low_addr_reg} :
      (paddr_in == CBC_OFS_STATUS) ? {24'h0, 1'b0, nmi_latch_reg,
                                      rst_latch_reg, 2'h0, state_reg} :
      (paddr_in == CBC_OFS_ALU)    ? {21'h0, alu_op_reg, alu_b_reg} :
      32'h0;

   // mask-bit effects of events and return from trap
   always_comb begin
      flags_next = flags_reg;
      if (apb_wr && paddr_in == CBC_OFS_EVENT) begin
         case (cbc_ev_t'(event_code))
            CBC_EV_NMI, CBC_EV_QUICK_INTERRUPT_REQUEST, CBC_EV_RESET, CBC_EV_TRAP1: begin
               flags_next[CBC_F_I] = 1'b1;                  // R9
               flags_next[CBC_F_F] = 1'b1;                  // R11
               flags_next[CBC_F_E] = (event_code != CBC_EV_QUICK_INTERRUPT_REQUEST); // R12
            end
            CBC_EV_IRQ: begin
               flags_next[CBC_F_I] = 1'b1;                  // R9
               flags_next[CBC_F_E] = 1'b1;
            end
            CBC_EV_TRAP2, CBC_EV_TRAP3: flags_next[CBC_F_E] = 1'b1;
            default: flags_next = pwdata_in[15:8];          // R12
         endcase
      end else if (apb_wr && paddr_in == CBC_OFS_FLAGS) begin
         flags_next = pwdata_in[7:0];
      end else if (apb_wr && paddr_in == CBC_OFS_ALU &&
                   pwdata_in[16]) begin
         flags_next = alu_res.flags;                        // R5
      end
      if (irq_take) flags_next[CBC_F_I] = 1'b1;
      if (quick_interrupt_request_take) begin
         flags_next[CBC_F_F] = 1'b1;
         flags_next[CBC_F_I] = 1'b1;
      end
      if (state_reg == CBC_ST_RESET) flags_next = CBC_FLAGS_RST;
   end

   // register writes, one bus access per cycle
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         acc_a_reg     <= 8'h00;
         acc_b_reg     <= 8'h00;
         flags_reg     <= CBC_FLAGS_RST;
         page_reg      <= CBC_PAGE_RST;
         sstack_reg    <= CBC_STACK_RST;
         ustack_reg    <= CBC_STACK_RST;
         alu_b_reg     <= 8'h00;
         alu_op_reg    <= CBC_OP_ADD;
         direct_reg    <= 1'b0;
         low_addr_reg  <= 8'h00;
         write_req_reg <= 1'b0;
         xfer_req_reg  <= 1'b0;
         instr_end_reg <= 1'b1;
      end else if (clk_en_in) begin
         flags_reg <= flags_next;
         if (state_reg == CBC_ST_RESET) page_reg <= CBC_PAGE_RST; // R3
         else if (apb_wr && paddr_in == CBC_OFS_PAGE)
            page_reg <= pwdata_in[7:0];
         if (apb_wr && paddr_in == CBC_OFS_ACC) begin
            acc_a_reg <= pwdata_in[15:8];                   // R24
            acc_b_reg <= pwdata_in[7:0];                    // R24
         end else if (apb_wr && paddr_in == CBC_OFS_ALU && pwdata_in[16])
            acc_a_reg <= alu_res.result;
         // pointer holds the address of the last pushed item
         if (apb_wr && paddr_in == CBC_OFS_STACK)
            sstack_reg <= pwdata_in[15:0];                  // R4
         if (apb_wr && paddr_in == CBC_OFS_USTACK)
            ustack_reg <= pwdata_in[15:0];                  // R4
         if (apb_wr && paddr_in == CBC_OFS_ALU) begin
            alu_b_reg  <= pwdata_in[7:0];
            alu_op_reg <= cbc_op_t'(pwdata_in[10:8]);
         end
         if (apb_wr && paddr_in == CBC_OFS_CTRL) begin
            low_addr_reg  <= pwdata_in[7:0];
            instr_end_reg <= pwdata_in[8];
            direct_reg    <= pwdata_in[9];
            write_req_reg <= pwdata_in[10];
            xfer_req_reg  <= pwdata_in[11];
         end
      end
   end

   // ==========================================================
   // bus pin values
   cbc_bus_t bus_next;
   logic     released;

   assign released = (state_reg == CBC_ST_GRANT) ||
                     (state_reg == CBC_ST_HALT) ||
                     (state_reg == CBC_ST_RESET && !halt_n_s);
   always_comb begin
      bus_next.bus_released = released;                    // R22
      bus_next.bus_state    = released ||
                              (state_reg == CBC_ST_VECTOR); // R22
      if (state_reg == CBC_ST_VECTOR) begin
         bus_next.addr = CBC_VEC_RESET | {15'h0, cyc_cnt_reg[1]}; // R16
         bus_next.read = 1'b1;
      end else if (state_reg == CBC_ST_RUN && xfer_req_reg) begin
         bus_next.addr = {direct_reg ? page_reg : 8'h00,
                          low_addr_reg};                    // R2
         bus_next.read = !write_req_reg;                    // R15
      end else begin
         bus_next.addr = CBC_IDLE_ADDR;                     // R13
         bus_next.read = 1'b1;                              // R13
      end
   end

   // registered outputs, stable for the whole cycle
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         addr_out         <= CBC_IDLE_ADDR;
         addr_oe_out      <= 1'b1;
         read_out         <= 1'b1;
         bus_released_out <= 1'b0;
         bus_state_out    <= 1'b0;
         prdata_out       <= 32'h0;
         pready_out       <= 1'b0;
         pslverr_out      <= 1'b0;
      end else if (clk_en_in) begin
         addr_out         <= bus_next.addr;
         addr_oe_out      <= !bus_next.bus_released;       // R14
         read_out         <= bus_next.read;
         bus_released_out <= bus_next.bus_released;         // R17
         bus_state_out    <= bus_next.bus_state;
         pready_out       <= psel_in && !penable_in;
         pslverr_out      <= psel_in && !penable_in && !hit;
         if (apb_rd) prdata_out <= hit ? rd_mux : 32'h0;
      end
   end
endmodule
`default_nettype wire

// File: verif/cbc_checker.sv
// cbc_checker: port assertions for cbc_top
// assumes: bound to cbc_top, one clock, sync reset rst_in
`default_nettype none
module cbc_checker
   import cbc_pkg::*;
(
   // clock, reset, apb
   input wire logic        sys_clk_in,
   input wire logic        rst_in,
   input wire logic        psel_in,
   input wire logic        penable_in,
   input wire logic        pready_out,
   // bus pins
   input wire logic [15:0] addr_out,
   input wire logic        addr_oe_out,
   input wire logic        read_out,
   input wire logic        bus_released_out,
   input wire logic        bus_state_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);
   // =========
   // apb answer
   AST_APB_READY: assert property (psel_in && !penable_in |=> pready_out)
      else $error("no pready after setup");
   AST_READY_ONE: assert property (pready_out |=> !pready_out)
      else $error("pready held too long");
   // =========
   // bus state
   AST_FLOAT:
      assert property (addr_oe_out != bus_released_out)
      else $error("address drive disagrees with release");
   AST_NO_SYNC:
      assert property (bus_released_out |-> bus_state_out)
      else $error("released without state high");
   AST_VEC_ADDR:
      assert property (bus_state_out && !bus_released_out
         |-> addr_out[15:4] == 12'hfff && read_out)
      else $error("ack outside vector area");
   AST_VEC_LEN:
      assert property ($rose(bus_state_out) && !bus_released_out
         |-> (bus_state_out && !bus_released_out) [*4] ##1 !bus_state_out)
      else $error("vector fetch length wrong");
   AST_DEAD:
      assert property ($fell(bus_released_out) |-> !bus_state_out
         && addr_out == CBC_IDLE_ADDR && read_out)
      else $error("no dead cycle after release");
   AST_RST_IDLE:
      assert property (disable iff (1'b0) rst_in |=> read_out
         && addr_out == CBC_IDLE_ADDR && addr_oe_out && !bus_state_out)
      else $error("reset does not idle bus");
endmodule
`default_nettype wire

// File: verif/cbc_partner.sv
// cbc_partner: pin side model of reset, halt, steal, interrupts
// assumes: bench calls its tasks just after a clock edge
`default_nettype none
module cbc_partner (
   // clock and bus status
   input  wire logic sys_clk_in,
   input  wire logic bus_released_in,
   // requests, active low
   output logic      reset_n_out,
   output logic      halt_n_out,
   output logic      steal_n_out,
   output logic      nmi_n_out,
   output logic      quick_n_out,
   output logic      irq_n_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // all requests idle from time zero
   initial begin
      {reset_n_out, halt_n_out, steal_n_out} = 3'h7;
      {nmi_n_out, quick_n_out, irq_n_out} = 3'h7;
   end
   // levels held whole cycles; reset held past one bus cycle
   task automatic drive(input logic [5:0] v, input int n);
      @(posedge sys_clk_in);
      {reset_n_out, halt_n_out, steal_n_out} <= v[5:3];
      {nmi_n_out, quick_n_out, irq_n_out} <= v[2:0];
      repeat (n) @(posedge sys_clk_in);
   endtask
   // drop a steal and wait one clock past the release falling
   task automatic end_steal();
      drive(6'h3f, 1);
      for (int k = 0; k < 40 && bus_released_in; k++)
         @(posedge sys_clk_in);
      @(posedge sys_clk_in);
   endtask
endmodule
`default_nettype wire

// File: verif/cpu_bus_control_and_flags_test.sv
// cpu_bus_control_and_flags_test: scenarios for cbc_top
// assumes: cbc_pkg, cbc_top, cbc_partner and cbc_checker compiled
`default_nettype none
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin \
   fails++; $display("MISMATCH %s exp %0h got %0h", nm, ex, got); end end
module cpu_bus_control_and_flags_test;
   timeunit 1ns;
   timeprecision 1ps;
   import cbc_pkg::*;
   localparam logic [13:0] EV_MASKS = 14'h03df;
   logic        clk, rst, psel, penable, pwrite, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic        pready, pslverr, oe, rdf, rel, bst;
   logic [15:0] addr;
   wire  logic  rn, hn, sn, nn, qn, in_n;
   int          fails, checks_done;
   cbc_partner i_far (.sys_clk_in(clk), .bus_released_in(rel),
      .reset_n_out(rn), .halt_n_out(hn), .steal_n_out(sn),
      .nmi_n_out(nn), .quick_n_out(qn), .irq_n_out(in_n));
   cbc_top i_dut (.sys_clk_in(clk), .rst_in(rst), .clk_en_in(1'b1),
      .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
      .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr), .reset_n_in(rn),
      .halt_n_in(hn), .bus_steal_request_n_in(sn), .nmi_n_in(nn),
      .quick_interrupt_request_n_in(qn), .irq_n_in(in_n),
      .addr_out(addr), .addr_oe_out(oe), .read_out(rdf),
      .bus_released_out(rel), .bus_state_out(bst));
   // =========
   // clock and bus tasks
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, x);
      apb(1'b0, a, 32'h0);
      `CHK($sformatf("reg %h", a), x, r & m)
   endtask
   task automatic wait_st(input logic [1:0] s);
      for (int k = 0; k < 60 && {rel, bst} !== s; k++) @(posedge clk);
      `CHK("status", s, {rel, bst})
   endtask
   task automatic wait_addr(input logic [15:0] a);
      for (int k = 0; k < 60 && addr !== a; k++) @(posedge clk);
      `CHK("address", a, addr)
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // =========
   // scenarios
   task automatic t_regs();
      rd_chk(CBC_OFS_FLAGS, 32'hff, 32'h50);
      rd_chk(CBC_OFS_PAGE, 32'hff, 32'h0);
      apb(1'b1, CBC_OFS_ACC, 32'h12ab);
      rd_chk(CBC_OFS_ACC, 32'hffffffff, 32'h12ab);
      apb(1'b1, CBC_OFS_STACK, 32'h1234);
      rd_chk(CBC_OFS_STACK, 32'hffffffff, 32'h1234);
      apb(1'b0, 12'h0fc, 32'h0);
      `CHK("refused", 2'b10, {e, |r})
      apb(1'b1, CBC_OFS_PAGE, 32'hff);
      i_far.drive(6'h1f, 12);
      i_far.drive(6'h3f, 0);
      wait_st(2'b01);
      `CHK("vector", CBC_VEC_RESET[15:1], addr[15:1])
      rd_chk(CBC_OFS_PAGE, 32'hff, 32'h0);
   endtask
   task automatic alu(input cbc_op_t op, input logic [7:0] a, b, f, m, xf, xr);
      apb(1'b1, CBC_OFS_FLAGS, {24'h0, f});
      apb(1'b1, CBC_OFS_ACC, {16'h0, a, 8'h0});
      apb(1'b1, CBC_OFS_ALU, {21'h0, op, b}); // operands first
      apb(1'b1, CBC_OFS_ALU, {15'h0, 1'b1, 5'h0, op, b});
      rd_chk(CBC_OFS_FLAGS, {24'h0, m}, {24'h0, xf & m});
      if (op != CBC_OP_CMP)
         rd_chk(CBC_OFS_ACC, 32'hff00, {16'h0, xr, 8'h0});
   endtask
   task automatic t_alu();
      alu(CBC_OP_ADD, 8'h7f, 8'h01, 8'h00, 8'h2f, 8'h2a, 8'h80);
      alu(CBC_OP_ADD, 8'hff, 8'h01, 8'h00, 8'h2f, 8'h25, 8'h00);
      alu(CBC_OP_ADC, 8'h0e, 8'h01, 8'h01, 8'h2f, 8'h20, 8'h10);
      alu(CBC_OP_SUB, 8'h00, 8'h01, 8'h00, 8'h0f, 8'h09, 8'hff);
      alu(CBC_OP_SBC, 8'h05, 8'h02, 8'h01, 8'h0f, 8'h00, 8'h02);
      alu(CBC_OP_CMP, 8'h80, 8'h01, 8'h00, 8'h0f, 8'h02, 8'h00);
      alu(CBC_OP_NEG, 8'h01, 8'h01, 8'h00, 8'h0f, 8'h09, 8'hff);
      alu(CBC_OP_AND, 8'hf0, 8'h0f, 8'h20, 8'h24, 8'h24, 8'h00);
   endtask
   task automatic t_events();
      for (int i = 0; i < 7; i++) begin
         apb(1'b1, CBC_OFS_FLAGS, 32'h0);
         apb(1'b1, CBC_OFS_EVENT, 32'(i));
         rd_chk(CBC_OFS_FLAGS, 32'h50, {25'h0, EV_MASKS[2*i+1], 1'b0,
                EV_MASKS[2*i], 4'h0});
      end
      apb(1'b1, CBC_OFS_EVENT, 32'h8007);
      rd_chk(CBC_OFS_FLAGS, 32'hff, 32'h80);
   endtask
   task automatic t_bus();
      apb(1'b1, CBC_OFS_PAGE, 32'h3c);
      apb(1'b1, CBC_OFS_CTRL, 32'hb5a);
      wait_addr(16'h3c5a);
      `CHK("direction", 1'b1, rdf)
      apb(1'b1, CBC_OFS_CTRL, 32'hd21);
      wait_addr(16'h0021);
      `CHK("direction", 1'b0, rdf)
      apb(1'b1, CBC_OFS_CTRL, 32'h100);
      wait_addr(CBC_IDLE_ADDR);
      `CHK("idle", 2'b10, {rdf, bst})
   endtask
   task automatic t_halt();
      i_far.drive(6'h2f, 0);
      wait_st(2'b11);
      `CHK("addr drive", 1'b0, oe)
      i_far.drive(6'h28, 12);
      i_far.drive(6'h2f, 12);
      wait_st(2'b11);
      rd_chk(CBC_OFS_STATUS, 32'h47, 32'h45);
      rd_chk(CBC_OFS_FLAGS, 32'h50, 32'h0);
      i_far.drive(6'h3f, 0);
      wait_st(2'b00);
      i_far.drive(6'h37, 0);
      wait_st(2'b11);
      rd_chk(CBC_OFS_STATUS, 32'h7, 32'h3);
      i_far.end_steal();
      wait_st(2'b00);
      i_far.drive(6'h27, 0);
      wait_st(2'b11);
      i_far.drive(6'h2f, 8);
      rd_chk(CBC_OFS_STATUS, 32'h7, 32'h5);
      i_far.drive(6'h1f, 12);
      i_far.drive(6'h0f, 12);
      wait_st(2'b11);
      i_far.drive(6'h2f, 4);
      i_far.drive(6'h3f, 0);
      wait_st(2'b01);
   endtask
   // =========
   // main sequence and watchdog
   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h0;
      pwdata = 32'h0;
      fails = 0;
      checks_done = 0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_alu();
      t_events();
      t_bus();
      t_halt();
      complete_run();
   end
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      complete_run();
   end
endmodule
bind cbc_top cbc_checker i_chk (.sys_clk_in, .rst_in, .psel_in,
   .penable_in, .pready_out, .addr_out, .addr_oe_out, .read_out,
   .bus_released_out, .bus_state_out);
`default_nettype wire
